// ### lpm_chk.sv
// Assertion checker for the pin link and the driver end behind it
`timescale 1ns/1ps
`default_nettype none
module lpm_chk #(
  parameter logic [19:0] SHDN_CYCLES  = 20'h3e80,
  parameter logic [19:0] ERROR_CYCLES = 20'h3e80
) (
  // Clock, reset and pin
  input wire logic               i_clock,
  input wire logic               i_rstn,
  input wire logic               en_pin,
  // Driver end
  input wire logic               i_temp_over,
  input wire logic               i_temp_cooled,
  input wire logic               o_led_on,
  input wire logic [7:0]         o_current_code,
  input wire logic               o_converter_on,
  input wire logic               o_thermal_shdn,
  input wire logic               o_cmd_error,
  input wire lpm_pkg::lpm_mode_e o_mode
);
  // ------
  // Run counters, saturating so a stuck pin never wraps
  // ------
  logic [19:0] low_q, low_d, err_q, err_d;
  always_comb begin
    low_d = en_pin ? 20'h0 : low_q + {19'h0, ~&low_q};
    err_d = o_cmd_error ? err_q + {19'h0, ~&err_q} : 20'h0;
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      low_q <= 20'h0;
      err_q <= 20'h0;
    end else begin
      low_q <= low_d;
      err_q <= err_d;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  thermal_trip_a: assert property (i_temp_over [*6] |-> o_thermal_shdn)
    else $error("thermal trip not taken");
  thermal_off_a: assert property (o_thermal_shdn ##1 o_thermal_shdn |-> !o_led_on && !o_converter_on)
    else $error("converter runs in thermal shutdown");
  thermal_resume_a: assert property ((!i_temp_over && i_temp_cooled) [*6] |-> !o_thermal_shdn)
    else $error("thermal shutdown not left");
  pin_low_off_a: assert property (low_q > SHDN_CYCLES + 20'h8 |-> o_mode == lpm_pkg::MODE_OFF && !o_converter_on)
    else $error("long low did not shut down");
  error_bound_a: assert property (err_q <= ERROR_CYCLES + 20'h8)
    else $error("error state outlived its timeout");
  led_gate_a: assert property ($rose(en_pin) && o_mode == lpm_pkg::MODE_PWM && !o_thermal_shdn
    ##1 (en_pin && !i_temp_over) [*6] |-> o_led_on) else $error("dimming pulse did not light string");
  led_idle_a: assert property ((o_mode != lpm_pkg::MODE_PWM) [*2] |-> !o_led_on)
    else $error("string lit outside dimming mode");
  code_hold_a: assert property (o_mode == lpm_pkg::MODE_PWM ##1 o_mode == lpm_pkg::MODE_PWM |-> $stable(o_current_code))
    else $error("current changed while dimming");
  code_mode_a: assert property ($changed(o_current_code) |-> o_mode == lpm_pkg::MODE_PWM || o_mode == lpm_pkg::MODE_OFF)
    else $error("current changed outside mode entry");
endmodule
`default_nettype wire

// ### lpm_device.sv
// LED driver end: mode selection, serial current command and PWM gating
`timescale 1ns/1ps
`default_nettype none
module lpm_device #(
  parameter logic [7:0]  PRESET_CODE  = lpm_pkg::PRESET_30MA,
  parameter logic [19:0] SHDN_CYCLES  = lpm_pkg::SHDN_CYC,
  parameter logic [19:0] ERROR_CYCLES = lpm_pkg::SHDN_CYC
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rstn,
  // Link from host
  lpm_link_if.dev            link,
  // Temperature indications, asynchronous
  input  wire logic          i_temp_over,
  input  wire logic          i_temp_cooled,
  // Regulator control
  output logic               o_led_on,
  output logic [7:0]         o_current_code,
  output logic               o_converter_on,
  output logic               o_thermal_shdn,
  output logic               o_cmd_error,
  output lpm_pkg::lpm_mode_e o_mode
);
  localparam int CW = lpm_pkg::CW;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_FIRST,
    ST_SETTLE,
    ST_AUTO,
    ST_CMD,
    ST_CONFIRM,
    ST_PWM,
    ST_ERROR
  } lpm_dev_state_e;
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  // Pin one cycle late, so it lines up with the meter's edge events
  logic       level_q;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= {i_temp_cooled, i_temp_over, link.en_pin};
      sync2_q <= sync1_q;
      level_q <= sync2_q[0];
    end
  end

  logic pin, hot, cooled, level;
  assign pin    = sync2_q[0];
  assign hot    = sync2_q[1];
  assign cooled = sync2_q[2];
  assign level  = level_q;

  // ----------------------------------------------------------------
  // Pulse measurement
  // ----------------------------------------------------------------
  logic          rise, fall;
  logic [CW-1:0] width, run;
  lpm_pulse_meter #(.CW(CW)) u_meter (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_level (pin),
    .o_rise  (rise),
    .o_fall  (fall),
    .o_width (width),
    .o_run   (run)
  );

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  lpm_dev_state_e state_q, state_d;
  logic [15:0]    shift_q, shift_d;
  logic [4:0]     nbits_q, nbits_d;
  logic [CW-1:0]  hi_q, hi_d;
  logic [CW-1:0]  err_q, err_d;
  logic [7:0]     code_q, code_d;
  logic           bit_ok;
  logic           bit_val;
  always_comb begin
    // Bit classified purely by its high time
    bit_val = (width >= lpm_pkg::BIT1_MIN_CYC) && (width <= lpm_pkg::BIT1_MAX_CYC);
    bit_ok  = bit_val ||
              ((width >= lpm_pkg::BIT0_MIN_CYC) && (width <= lpm_pkg::BIT0_MAX_CYC));
    state_d = state_q;
    shift_d = shift_q;
    nbits_d = nbits_q;
    hi_d    = hi_q;
    err_d   = '0;
    code_d  = code_q;
    case (state_q)
      ST_OFF: begin
        if (rise) begin
          state_d = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (fall) begin
          if (width >= lpm_pkg::PWM_SEL_MIN_CYC && width <= lpm_pkg::PWM_SEL_MAX_CYC) begin
            state_d = ST_SETTLE;
          end else if (width >= lpm_pkg::SER_SEL_MIN_CYC && width <= lpm_pkg::SER_SEL_MAX_CYC) begin
            state_d = ST_CMD;
            nbits_d = 5'h0;
            shift_d = 16'h0000;
          end else if (width < lpm_pkg::AUTO_PER_CYC) begin
            state_d = ST_AUTO;
            hi_d    = width;
          end else begin
            state_d = ST_ERROR;
          end
        end else if (level && run > lpm_pkg::SER_SEL_MAX_CYC) begin
          // A fully-on input never selects a mode
          state_d = ST_ERROR;
        end
      end
      ST_SETTLE: begin
        if (rise) begin
          state_d = ST_ERROR;
        end else if (run >= lpm_pkg::SETTLE_MIN_CYC) begin
          state_d = ST_PWM;
          code_d  = PRESET_CODE;
        end
      end
      ST_AUTO: begin
        // One short, fast period is enough to recognise dimming
        if (rise) begin
          if (hi_q < width && (hi_q + width) < lpm_pkg::AUTO_PER_CYC) begin
            state_d = ST_PWM;
            code_d  = PRESET_CODE;
          end else begin
            state_d = ST_ERROR;
          end
        end else if (run >= lpm_pkg::AUTO_PER_CYC) begin
          state_d = ST_ERROR;
        end
      end
      ST_CMD: begin
        if (fall) begin
          if (!bit_ok) begin
            state_d = ST_ERROR;
          end else begin
            shift_d = {shift_q[14:0], bit_val};
            nbits_d = nbits_q + 5'h1;
            if (nbits_q == 5'(lpm_pkg::CMD_BITS - 1)) begin
              state_d = ST_CONFIRM;
            end
          end
        end else if (!level && run >= lpm_pkg::EOC_MIN_CYC) begin
          // Command cut short
          state_d = ST_ERROR;
        end
      end
      ST_CONFIRM: begin
        if (rise) begin
          state_d = ST_ERROR;
        end else if (run >= lpm_pkg::EOC_MIN_CYC) begin
          if (shift_q[15:8] == lpm_pkg::CMD_UPPER) begin
            state_d = ST_PWM;
            code_d  = shift_q[7:0];
          end else begin
            state_d = ST_ERROR;
          end
        end
      end
      ST_PWM: begin
        // No decoding here: only a restart through shutdown reprograms
        state_d = ST_PWM;
      end
      ST_ERROR: begin
        err_d = err_q + CW'(1);
        if (err_q >= ERROR_CYCLES - CW'(1)) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (state_q != ST_OFF && !level && !rise && run >= SHDN_CYCLES) begin
      state_d = ST_OFF;
    end
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_OFF;
      shift_q <= 16'h0000;
      nbits_q <= 5'h0;
      hi_q    <= '0;
      err_q   <= '0;
      code_q  <= lpm_pkg::CODE_RESET;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      nbits_q <= nbits_d;
      hi_q    <= hi_d;
      err_q   <= err_d;
      code_q  <= code_d;
    end
  end

  // ----------------------------------------------------------------
  // Thermal protection
  // ----------------------------------------------------------------
  logic therm_q, therm_d;
  always_comb begin
    therm_d = therm_q;
    if (cooled) begin
      therm_d = 1'b0;
    end
    // Trip wins over a simultaneous cool indication
    if (hot) begin
      therm_d = 1'b1;
    end
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      therm_q <= 1'b0;
    end else begin
      therm_q <= therm_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic               led_q, led_d;
  logic               conv_q, conv_d;
  logic               cerr_q, cerr_d;
  lpm_pkg::lpm_mode_e mode_q, mode_d;
  always_comb begin
    // LEDs follow each dimming pulse at the stored current
    led_d  = (state_d == ST_PWM) && pin && !therm_d;
    conv_d = (state_d != ST_OFF) && (state_d != ST_ERROR) && !therm_d;
    cerr_d = (state_d == ST_ERROR);
    case (state_d)
      ST_OFF:               mode_d = lpm_pkg::MODE_OFF;
      ST_CMD, ST_CONFIRM:   mode_d = lpm_pkg::MODE_SERIAL;
      ST_PWM:               mode_d = lpm_pkg::MODE_PWM;
      ST_ERROR:             mode_d = lpm_pkg::MODE_ERROR;
      default:              mode_d = lpm_pkg::MODE_SELECT;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      led_q  <= 1'b0;
      conv_q <= 1'b0;
      cerr_q <= 1'b0;
      mode_q <= lpm_pkg::MODE_OFF;
    end else begin
      led_q  <= led_d;
      conv_q <= conv_d;
      cerr_q <= cerr_d;
      mode_q <= mode_d;
    end
  end

  assign o_led_on       = led_q;
  assign o_current_code = code_q;
  assign o_converter_on = conv_q;
  assign o_thermal_shdn = therm_q;
  assign o_cmd_error    = cerr_q;
  assign o_mode         = mode_q;
endmodule
`default_nettype wire

// ### lpm_host.sv
// Host end: generates select pulses, serial commands, dimming and shutdown
`timescale 1ns/1ps
`default_nettype none
module lpm_host #(
  parameter logic [19:0] SHDN_HOLD_CYCLES = lpm_pkg::SHDN_HOLD_CYC
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rstn,
  // User requests
  input  wire logic          i_start_pwm,
  input  wire logic          i_start_serial,
  input  wire logic [7:0]    i_code,
  input  wire logic          i_dim,
  input  wire logic          i_off,
  // Status
  output logic               o_busy,
  output logic               o_running,
  // Link to device
  lpm_link_if.host           link
);

  localparam int CW = lpm_pkg::CW;

  typedef enum logic [2:0] {
    H_OFF,
    H_SEL,
    H_SETTLE,
    H_GAP,
    H_BIT,
    H_EOC,
    H_RUN,
    H_SHDN
  } lpm_host_state_e;

  lpm_host_state_e state_q, state_d;
  logic [CW-1:0]   cnt_q, cnt_d;
  logic [15:0]     shift_q, shift_d;
  logic [4:0]      nbits_q, nbits_d;
  logic            serial_q, serial_d;
  logic            pin_q, pin_d;
  logic            busy_q, busy_d;
  logic            run_q, run_d;
  logic            done;

  assign done = (cnt_q == CW'(1));

  always_comb begin
    state_d  = state_q;
    cnt_d    = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
    shift_d  = shift_q;
    nbits_d  = nbits_q;
    serial_d = serial_q;
    case (state_q)
      H_OFF: begin
        if (i_start_pwm || i_start_serial) begin
          state_d  = H_SEL;
          serial_d = i_start_serial;
          cnt_d    = i_start_serial ? lpm_pkg::SER_SEL_CYC : lpm_pkg::PWM_SEL_CYC;
          shift_d  = {lpm_pkg::CMD_UPPER, i_code};
          nbits_d  = 5'h0;
        end
      end
      H_SEL: begin
        if (done) begin
          state_d = serial_q ? H_GAP : H_SETTLE;
          cnt_d   = serial_q ? lpm_pkg::GAP_CYC : lpm_pkg::SETTLE_CYC;
        end
      end
      H_SETTLE: begin
        if (done) begin
          state_d = H_RUN;
        end
      end
      H_GAP: begin
        if (done) begin
          state_d = H_BIT;
          cnt_d   = shift_q[15] ? lpm_pkg::BIT1_CYC : lpm_pkg::BIT0_CYC;
        end
      end
      H_BIT: begin
        if (done) begin
          shift_d = {shift_q[14:0], 1'b0};
          nbits_d = nbits_q + 5'h1;
          if (nbits_q == 5'(lpm_pkg::CMD_BITS - 1)) begin
            state_d = H_EOC;
            cnt_d   = lpm_pkg::EOC_CYC;
          end else begin
            state_d = H_GAP;
            cnt_d   = lpm_pkg::GAP_CYC;
          end
        end
      end
      H_EOC: begin
        if (done) begin
          state_d = H_RUN;
        end
      end
      H_RUN: begin
        if (i_off) begin
          state_d = H_SHDN;
          cnt_d   = SHDN_HOLD_CYCLES;
        end
      end
      H_SHDN: begin
        if (done) begin
          state_d = H_OFF;
        end
      end
      default: begin
        state_d = H_OFF;
      end
    endcase
    pin_d  = (state_d == H_SEL) || (state_d == H_BIT) || (state_d == H_RUN && i_dim);
    busy_d = (state_d != H_OFF) && (state_d != H_RUN);
    run_d  = (state_d == H_RUN);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q  <= H_OFF;
      cnt_q    <= '0;
      shift_q  <= 16'h0000;
      nbits_q  <= 5'h0;
      serial_q <= 1'b0;
      pin_q    <= 1'b0;
      busy_q   <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      shift_q  <= shift_d;
      nbits_q  <= nbits_d;
      serial_q <= serial_d;
      pin_q    <= pin_d;
      busy_q   <= busy_d;
      run_q    <= run_d;
    end
  end

  assign link.en_pin = pin_q;
  assign o_busy      = busy_q;
  assign o_running   = run_q;

endmodule
`default_nettype wire

// ### lpm_link_if.sv
// Enable/dimming pin between host controller and LED driver
`timescale 1ns/1ps
`default_nettype none
interface lpm_link_if;
  logic en_pin;
  modport host (output en_pin);
  modport dev  (input en_pin);
endinterface
`default_nettype wire

// ### lpm_pkg.sv
// Shared constants and types for the LED driver pulse-mode control link
package lpm_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int CW      = 20;

  // ----------------------------------------------------------------
  // Nominal host timing, microseconds except the _MS and _KHZ entries
  // ----------------------------------------------------------------
  localparam int PWM_SELECT_PULSE_WIDTH_US    = 100;
  localparam int SERIAL_SELECT_PULSE_WIDTH_US = 300;
  localparam int MODE_SETTLE_LOW_TIME_US      = 200;
  localparam int ZERO_BIT_PULSE_WIDTH_US      = 5;
  localparam int ONE_BIT_PULSE_WIDTH_US       = 15;
  localparam int BIT_GAP_LOW_TIME_US          = 5;
  localparam int END_OF_COMMAND_LOW_TIME_US   = 300;
  localparam int SHUTDOWN_LOW_TIME_MS         = 10;
  localparam int SHUTDOWN_HOLD_TIME_MS        = 11;
  localparam int AUTO_PWM_MIN_FREQ_KHZ        = 5;

  // ----------------------------------------------------------------
  // Device acceptance windows, microseconds
  // ----------------------------------------------------------------
  localparam int PWM_SEL_MIN_US = 80;
  localparam int PWM_SEL_MAX_US = 150;
  localparam int SER_SEL_MIN_US = 250;
  localparam int SER_SEL_MAX_US = 400;
  localparam int BIT0_MIN_US    = 2;
  localparam int BIT0_MAX_US    = 9;
  localparam int BIT1_MIN_US    = 10;
  localparam int BIT1_MAX_US    = 25;
  localparam int SETTLE_MIN_US  = 150;
  localparam int EOC_MIN_US     = 250;

  // ----------------------------------------------------------------
  // Cycle counts derived from the times above
  // ----------------------------------------------------------------
  localparam logic [CW-1:0] PWM_SEL_CYC  = CW'(PWM_SELECT_PULSE_WIDTH_US * CLK_MHZ);
  localparam logic [CW-1:0] SER_SEL_CYC  = CW'(SERIAL_SELECT_PULSE_WIDTH_US * CLK_MHZ);
  localparam logic [CW-1:0] SETTLE_CYC   = CW'(MODE_SETTLE_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] BIT0_CYC     = CW'(ZERO_BIT_PULSE_WIDTH_US * CLK_MHZ);
  localparam logic [CW-1:0] BIT1_CYC     = CW'(ONE_BIT_PULSE_WIDTH_US * CLK_MHZ);
  localparam logic [CW-1:0] GAP_CYC      = CW'(BIT_GAP_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] EOC_CYC      = CW'(END_OF_COMMAND_LOW_TIME_US * CLK_MHZ);
  localparam logic [CW-1:0] SHDN_CYC     = CW'(SHUTDOWN_LOW_TIME_MS * 1000 * CLK_MHZ);
  localparam logic [CW-1:0] SHDN_HOLD_CYC = CW'(SHUTDOWN_HOLD_TIME_MS * 1000 * CLK_MHZ);
  localparam logic [CW-1:0] AUTO_PER_CYC = CW'(1000 * CLK_MHZ / AUTO_PWM_MIN_FREQ_KHZ);
  localparam logic [CW-1:0] PWM_SEL_MIN_CYC = CW'(PWM_SEL_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] PWM_SEL_MAX_CYC = CW'(PWM_SEL_MAX_US * CLK_MHZ);
  localparam logic [CW-1:0] SER_SEL_MIN_CYC = CW'(SER_SEL_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] SER_SEL_MAX_CYC = CW'(SER_SEL_MAX_US * CLK_MHZ);
  localparam logic [CW-1:0] BIT0_MIN_CYC    = CW'(BIT0_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] BIT0_MAX_CYC    = CW'(BIT0_MAX_US * CLK_MHZ);
  localparam logic [CW-1:0] BIT1_MIN_CYC    = CW'(BIT1_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] BIT1_MAX_CYC    = CW'(BIT1_MAX_US * CLK_MHZ);
  localparam logic [CW-1:0] SETTLE_MIN_CYC  = CW'(SETTLE_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] EOC_MIN_CYC     = CW'(EOC_MIN_US * CLK_MHZ);

  // ----------------------------------------------------------------
  // Command format and current codes
  // ----------------------------------------------------------------
  localparam int         CMD_BITS    = 16;
  localparam logic [7:0] CMD_UPPER   = 8'h04;
  localparam logic [7:0] PRESET_20MA = 8'h9f;
  localparam logic [7:0] PRESET_25MA = 8'hc7;
  localparam logic [7:0] PRESET_30MA = 8'hef;
  localparam logic [7:0] CODE_RESET  = 8'h00;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_SELECT,
    MODE_SERIAL,
    MODE_PWM,
    MODE_ERROR
  } lpm_mode_e;

endpackage

// ### lpm_pulse_meter.sv
// Measures the length of each high and low phase of a synchronised level
`timescale 1ns/1ps
`default_nettype none
module lpm_pulse_meter #(
  parameter int CW = 20
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rstn,
  // Synchronised level
  input  wire logic          i_level,
  // Edge events and widths
  output logic               o_rise,
  output logic               o_fall,
  output logic [CW-1:0]      o_width,
  output logic [CW-1:0]      o_run
);

  logic          level_q, level_d;
  logic [CW-1:0] run_q, run_d;
  logic [CW-1:0] width_q, width_d;
  logic          rise_q, rise_d;
  logic          fall_q, fall_d;

  always_comb begin
    level_d = i_level;
    rise_d  = i_level && !level_q;
    fall_d  = !i_level && level_q;
    width_d = width_q;
    run_d   = run_q;
    if (i_level != level_q) begin
      // Width of the phase just ended; new phase counts its first cycle
      width_d = run_q;
      run_d   = CW'(1);
    end else if (run_q != {CW{1'b1}}) begin
      // Saturate so a very long low never wraps into a short one
      run_d = run_q + CW'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      level_q <= 1'b0;
      run_q   <= '0;
      width_q <= '0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      level_q <= level_d;
      run_q   <= run_d;
      width_q <= width_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

  assign o_rise  = rise_q;
  assign o_fall  = fall_q;
  assign o_width = width_q;
  assign o_run   = run_q;

endmodule
`default_nettype wire

// ### test_led_driver_pulse_mode_control.sv
// Bench: host and driver joined, plus a bench-driven second driver
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_pulse_mode_control;
  // ------
  // Signals and ends
  // ------
  localparam logic [19:0] SHDN = 20'h3e80;
  localparam logic [15:0] CMD  = {lpm_pkg::CMD_UPPER, 8'haf};
  logic               i_clock = 1'b0;
  logic               i_rstn = 1'b0;
  logic               st_pwm = 1'b0, st_ser = 1'b0, dim = 1'b0, off = 1'b0, t_over = 1'b0, t_cool = 1'b0;
  logic [7:0]         code = 8'h00;
  logic               busy, running, led, conv, therm, err, err_b;
  logic [7:0]         cur, cur_b;
  lpm_pkg::lpm_mode_e mode, mode_b;
  logic [19:0]        hcnt = 20'h0;
  logic [19:0]        widths[$];
  int                 n_errors = 0;
  int                 checks_done = 0;
  lpm_link_if lnk();
  lpm_link_if lnk_e();
  always #10 i_clock = ~i_clock;
  lpm_host #(.SHDN_HOLD_CYCLES(20'h4650)) lpm_host_i (.i_clock(i_clock), .i_rstn(i_rstn), .i_start_pwm(st_pwm),
    .i_start_serial(st_ser), .i_code(code), .i_dim(dim), .i_off(off), .o_busy(busy), .o_running(running), .link(lnk));
  lpm_device #(.SHDN_CYCLES(SHDN), .ERROR_CYCLES(SHDN)) lpm_device_i (.i_clock(i_clock), .i_rstn(i_rstn), .link(lnk),
    .i_temp_over(t_over), .i_temp_cooled(t_cool), .o_led_on(led), .o_current_code(cur), .o_converter_on(conv),
    .o_thermal_shdn(therm), .o_cmd_error(err), .o_mode(mode));
  // Second driver takes broken traffic; short error timeout keeps it apart from the long-low shutdown
  lpm_device #(.PRESET_CODE(lpm_pkg::PRESET_20MA), .SHDN_CYCLES(SHDN), .ERROR_CYCLES(20'h7d0)) lpm_device_e_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .link(lnk_e), .i_temp_over(1'b0), .i_temp_cooled(1'b0), .o_led_on(),
    .o_current_code(cur_b), .o_converter_on(), .o_thermal_shdn(), .o_cmd_error(err_b), .o_mode(mode_b));
  lpm_chk #(.SHDN_CYCLES(SHDN), .ERROR_CYCLES(SHDN)) lpm_chk_i (.i_clock(i_clock), .i_rstn(i_rstn),
    .en_pin(lnk.en_pin), .i_temp_over(t_over), .i_temp_cooled(t_cool), .o_led_on(led), .o_current_code(cur),
    .o_converter_on(conv), .o_thermal_shdn(therm), .o_cmd_error(err), .o_mode(mode));
  // High-time monitor on the joined pin
  always @(posedge i_clock) begin
    if (lnk.en_pin === 1'b1) begin
      hcnt <= hcnt + 20'h1;
    end else if (hcnt != 20'h0) begin
      widths.push_back(hcnt);
      hcnt <= 20'h0;
    end
  end
  // ------
  // Tasks
  // ------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic drive_e(input logic v, input int us);
    lnk_e.en_pin <= v;
    tick(us * lpm_pkg::CLK_MHZ);
  endtask
  task automatic pulse_e(input int hi_us, input int lo_us);
    drive_e(1'b1, hi_us);
    drive_e(1'b0, lo_us);
  endtask
  task automatic wait_idle(input int lim);
    tick(4);
    for (int i = 0; i < lim && busy !== 1'b0; i++) tick(1);
    check(20'(busy), 20'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial begin
    // Longest branch needs about 78000 cycles
    repeat (90000) @(posedge i_clock);
    n_errors++;
    print_verdict();
  end
  initial begin
    lnk_e.en_pin = 1'b0;
    tick(16);
    i_rstn <= 1'b1;
    tick(2);
    fork
      begin
        code <= 8'haf;
        st_ser <= 1'b1;
        tick(1);
        st_ser <= 1'b0;
        wait_idle(60000);
        check(20'(running), 20'h1);
        check(20'(mode), 20'(lpm_pkg::MODE_PWM));
        check(20'(cur), 20'haf);
        check(widths[0], lpm_pkg::SER_SEL_CYC);
        check(20'(widths.size()), 20'h11);
        for (int i = 0; i < 16; i++) check(widths[i + 1], CMD[15 - i] ? lpm_pkg::BIT1_CYC : lpm_pkg::BIT0_CYC);
        dim <= 1'b1;
        tick(20);
        check(20'(led), 20'h1);
        t_over <= 1'b1;
        tick(10);
        check(20'({therm, led, conv}), 20'h4);
        t_over <= 1'b0;
        t_cool <= 1'b1;
        tick(10);
        check(20'({therm, led}), 20'h1);
        t_cool <= 1'b0;
        dim <= 1'b0;
        tick(20);
        check(20'(led), 20'h0);
        off <= 1'b1;
        tick(1);
        off <= 1'b0;
        wait_idle(25000);
        check(20'({lnk.en_pin, 3'(mode)}), 20'(lpm_pkg::MODE_OFF));
        $display("serial start, dimming, thermal and shutdown done");
        widths.delete();
        st_pwm <= 1'b1;
        tick(1);
        st_pwm <= 1'b0;
        wait_idle(20000);
        check(widths[0], lpm_pkg::PWM_SEL_CYC);
        check(20'({3'(mode), cur}), 20'({3'(lpm_pkg::MODE_PWM), lpm_pkg::PRESET_30MA}));
        dim <= 1'b1;
        tick(20);
        check(20'(led), 20'h1);
        $display("select start and dimming done");
      end
      begin
        pulse_e(300, 5);
        pulse_e(40, 10);
        check(20'({err_b, 3'(mode_b)}), 20'({1'b1, 3'(lpm_pkg::MODE_ERROR)}));
        drive_e(1'b0, 60);
        check(20'(mode_b), 20'(lpm_pkg::MODE_OFF));
        pulse_e(300, 5);
        for (int i = 15; i >= 0; i--) pulse_e(i == 8 || i == 10 ? 15 : 5, 5);
        drive_e(1'b0, 260);
        check(20'(err_b), 20'h1);
        drive_e(1'b0, 50);
        for (int i = 0; i < 3; i++) pulse_e(20, 80);
        check(20'({3'(mode_b), cur_b}), 20'({3'(lpm_pkg::MODE_PWM), lpm_pkg::PRESET_20MA}));
        pulse_e(15, 5);
        pulse_e(15, 10);
        check(20'({3'(mode_b), cur_b}), 20'({3'(lpm_pkg::MODE_PWM), lpm_pkg::PRESET_20MA}));
        $display("fault, auto start and ignored command done");
      end
    join
    print_verdict();
  end
endmodule
`default_nettype wire
